// file: logic/acr_adc_config.sv
`timescale 1ns/100ps
// Behaviour
// - Ext enable low: internal reference, level field
// - Ext enable high: reference from pin zero
// - Level codes VDD,4V,3V,2V; reset 11
// - Sample pulse 1,2,4,8 clocks; reset 10
// - Resolution 8,10,12 bits; reset 10
// - Port A pins 0-4 analog-only bits
// - Port B analog-only bits split across registers
// - Signed five-bit offset trim on results
// - Converter clock divides 16,8,1,2
// - Start bit begins; done flag reports end
module acr_adc_config
  import acr_pkg::*;
(
  input wire logic clk, // 200 MHz
  input wire logic sys_rst, // Sync reset, high
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, next cycle
  output logic ref_internal_en, // Internal reference on
  output logic ref_from_pin, // Reference from porta_pin_zero
  output logic [1:0] internal_reference_level, // Reference level code
  output logic [4:0] porta_analog_only, // Digital input disable
  output logic [5:0] portb_analog_only, // Digital input disable
  output logic conv_clk_en, // Converter clock pulse
  output logic sample_pulse, // Sampling window to core
  output logic conv_busy, // Conversion in progress
  output logic [3:0] result_bits, // Resolution in bits
  output logic trim_direction, // 1 raises, 0 lowers
  output logic [4:0] trim_magnitude, // Offset magnitude
  output logic conv_done // Result available
);

  logic [7:0] refh_q;
  logic [7:0] smpr_q;
  logic [7:0] pins_q;
  logic [7:0] trim_q;
  logic [1:0] ckdiv_q;
  logic [7:0] rdata_q;
  logic [4:0] div_cnt_q;
  logic tick_q;
  logic [3:0] step_q;
  logic done_q;
  acr_state_e state_q;
  acr_cfg_s cfg_q;

  wire sel_refh = reg_addr == ACR_OFF_REFH;
  wire sel_smpr = reg_addr == ACR_OFF_SMPR;
  wire sel_pins = reg_addr == ACR_OFF_PINS;
  wire sel_trim = reg_addr == ACR_OFF_TRIM;
  wire sel_ctrl = reg_addr == ACR_OFF_CTRL;
  wire start_wr = reg_wr && sel_ctrl && reg_wdata[ACR_BIT_START];

  // Only bits that exist are stored
  wire [7:0] refh_d = reg_wdata & ACR_MSK_REFH;
  wire [7:0] smpr_d = reg_wdata & ACR_MSK_SMPR;
  wire [7:0] trim_d = reg_wdata & ACR_MSK_TRIM;

  wire [7:0] ctrl_rd = {2'h0, ckdiv_q, 2'h0, done_q, 1'b0};
  wire [7:0] rdata_d = sel_refh ? refh_q :
                       sel_smpr ? smpr_q :
                       sel_pins ? pins_q :
                       sel_trim ? trim_q :
                       sel_ctrl ? ctrl_rd : 8'h00;

  // Divider selection
  wire [4:0] div_max = (ckdiv_q == 2'h0) ? ACR_DIV_00 :
                       (ckdiv_q == 2'h1) ? ACR_DIV_01 :
                       (ckdiv_q == 2'h2) ? ACR_DIV_10 : ACR_DIV_11;
  wire div_wrap = div_cnt_q >= div_max - 5'h01;

  // Sample length from the latched field
  wire [3:0] smp_len = 4'h1 << cfg_q.sample_pulse_width;
  // Resolution from latched field
  wire [3:0] res_bits = cfg_q.resolution_select[1] ? ACR_BITS_12 :
                        cfg_q.resolution_select[0] ? ACR_BITS_10 : ACR_BITS_8;

  wire [7:0] smpr_now = smpr_q;
  wire [7:0] refh_now = refh_q;
  acr_cfg_s cfg_d;
  assign cfg_d = '{ext_reference_enable: refh_now[ACR_BIT_EXTREF],
                   internal_reference_level: refh_now[1:0],
                   sample_pulse_width: smpr_now[3:2],
                   resolution_select: smpr_now[1:0],
                   offset_trim_direction: trim_q[ACR_BIT_SIGN],
                   offset_trim_magnitude: trim_q[4:0]};

  // Latched copy starts from register reset values, so outputs agree with reads
  acr_cfg_s cfg_rst;
  assign cfg_rst = '{ext_reference_enable: ACR_RST_REFH[ACR_BIT_EXTREF],
                     internal_reference_level: ACR_RST_REFH[1:0],
                     sample_pulse_width: ACR_RST_SMPR[3:2],
                     resolution_select: ACR_RST_SMPR[1:0],
                     offset_trim_direction: ACR_RST_TRIM[ACR_BIT_SIGN],
                     offset_trim_magnitude: ACR_RST_TRIM[4:0]};

  // Register file
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      refh_q <= ACR_RST_REFH;
      smpr_q <= ACR_RST_SMPR;
      pins_q <= ACR_RST_PINS;
      trim_q <= ACR_RST_TRIM;
      ckdiv_q <= ACR_RST_CKDIV;
      rdata_q <= 8'h00;
    end else begin
      if (reg_wr && sel_refh) refh_q <= refh_d;
      if (reg_wr && sel_smpr) smpr_q <= smpr_d;
      if (reg_wr && sel_pins) pins_q <= reg_wdata;
      if (reg_wr && sel_trim) trim_q <= trim_d;
      if (reg_wr && sel_ctrl) ckdiv_q <= reg_wdata[ACR_POS_CKDIV +: 2];
      if (reg_rd) rdata_q <= rdata_d;
      else rdata_q <= 8'h00;
    end
  end

  // Converter clock enable, free running
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_cnt_q <= 5'h00;
      tick_q <= 1'b0;
    end else begin
      div_cnt_q <= div_wrap ? 5'h00 : div_cnt_q + 5'h01;
      tick_q <= div_wrap;
    end
  end

  // Conversion sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ACR_IDLE;
      step_q <= 4'h0;
      done_q <= 1'b1;
      cfg_q <= cfg_rst;
    end else begin
      case (state_q)
        ACR_IDLE: begin
          if (start_wr) begin
            cfg_q <= cfg_d;
            done_q <= 1'b0;
            step_q <= 4'h0;
            state_q <= ACR_SAMPLE;
          end
        end
        ACR_SAMPLE: begin
          if (tick_q) begin
            if (step_q == smp_len - 4'h1) begin
              step_q <= 4'h0;
              state_q <= ACR_CONVERT;
            end else begin
              step_q <= step_q + 4'h1;
            end
          end
        end
        ACR_CONVERT: begin
          if (tick_q) begin
            if (step_q == res_bits - 4'h1) begin
              done_q <= 1'b1;
              state_q <= ACR_IDLE;
            end else begin
              step_q <= step_q + 4'h1;
            end
          end
        end
        default: begin
          state_q <= ACR_IDLE;
        end
      endcase
    end
  end

  // Pad outputs follow live registers; reference and conversion fields are latched
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ref_internal_en <= 1'b1;
      ref_from_pin <= 1'b0;
      internal_reference_level <= ACR_RST_REFH[1:0];
      porta_analog_only <= 5'h00;
      portb_analog_only <= 6'h00;
      conv_clk_en <= 1'b0;
      sample_pulse <= 1'b0;
      conv_busy <= 1'b0;
      result_bits <= 4'h0;
      trim_direction <= 1'b0;
      trim_magnitude <= 5'h00;
      conv_done <= 1'b1;
    end else begin
      ref_internal_en <= ~cfg_q.ext_reference_enable;
      ref_from_pin <= cfg_q.ext_reference_enable;
      internal_reference_level <= cfg_q.internal_reference_level;
      porta_analog_only <= pins_q[4:0];
      portb_analog_only <= {smpr_q[6:4], pins_q[7:5]};
      conv_clk_en <= tick_q;
      sample_pulse <= state_q == ACR_SAMPLE;
      conv_busy <= state_q != ACR_IDLE;
      result_bits <= res_bits;
      trim_direction <= cfg_q.offset_trim_direction;
      trim_magnitude <= cfg_q.offset_trim_magnitude;
      conv_done <= done_q;
    end
  end

  assign reg_rdata = rdata_q;

  property p_start_clears_done;
    @(posedge clk) disable iff (sys_rst)
    (start_wr && state_q == ACR_IDLE) |=> !done_q ##1 !conv_done;
  endproperty
  a_start_clears_done: assert property (p_start_clears_done) else $error("done not cleared");

  property p_extref;
    @(posedge clk) disable iff (sys_rst)
    cfg_q.ext_reference_enable |=> (ref_from_pin && !ref_internal_en);
  endproperty
  a_extref: assert property (p_extref) else $error("external reference not taken");

  property p_intref;
    @(posedge clk) disable iff (sys_rst)
    !cfg_q.ext_reference_enable |=> (ref_internal_en && !ref_from_pin);
  endproperty
  a_intref: assert property (p_intref) else $error("internal reference not taken");

  property p_porta;
    @(posedge clk) disable iff (sys_rst)
    ##1 porta_analog_only == $past(pins_q[4:0]);
  endproperty
  a_porta: assert property (p_porta) else $error("port A analog bits wrong");

  property p_portb;
    @(posedge clk) disable iff (sys_rst)
    ##1 portb_analog_only == {$past(smpr_q[6:4]), $past(pins_q[7:5])};
  endproperty
  a_portb: assert property (p_portb) else $error("port B analog bits wrong");

  property p_reserved;
    @(posedge clk) disable iff (sys_rst)
    (refh_q[6:2] == 5'h00) && !smpr_q[7] && (trim_q[7:6] == 2'h0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("unimplemented bit set");

  property p_cfg_hold;
    @(posedge clk) disable iff (sys_rst)
    (state_q != ACR_IDLE) |=> $stable(cfg_q);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config moved mid-conversion");

  property p_tick_spacing;
    @(posedge clk) disable iff (sys_rst)
    // Divider may be rewritten mid-window; only a steady setting is judged
    (tick_q && ckdiv_q == 2'h1) ##1 (ckdiv_q == 2'h1) [*7] |=> tick_q && !$past(tick_q);
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("divide by 8 wrong");

  property p_sample_len;
    @(posedge clk) disable iff (sys_rst)
    (state_q == ACR_SAMPLE && cfg_q.sample_pulse_width == 2'h0 && tick_q)
      |=> state_q == ACR_CONVERT;
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("one-clock sample wrong");

  property p_trim;
    @(posedge clk) disable iff (sys_rst)
    ##1 trim_magnitude == $past(cfg_q.offset_trim_magnitude);
  endproperty
  a_trim: assert property (p_trim) else $error("trim not applied");

  property p_level_reset;
    @(posedge clk) disable iff (sys_rst)
    $fell(sys_rst) |=> internal_reference_level == ACR_RST_REFH[1:0];
  endproperty
  a_level_reset: assert property (p_level_reset) else $error("level not 11 after reset");

  property p_pins_reset;
    @(posedge clk) disable iff (sys_rst)
    $fell(sys_rst) |-> (porta_analog_only == 5'h00) && (portb_analog_only == 6'h00);
  endproperty
  a_pins_reset: assert property (p_pins_reset) else $error("pins not clear after reset");

  property p_level_latch;
    @(posedge clk) disable iff (sys_rst)
    (start_wr && state_q == ACR_IDLE) |=> ##1 internal_reference_level == $past(refh_q[1:0], 2);
  endproperty
  a_level_latch: assert property (p_level_latch) else $error("level not latched");

  property p_res_low;
    @(posedge clk) disable iff (sys_rst)
    (start_wr && state_q == ACR_IDLE && smpr_q[1:0] == 2'h0) |=> ##1 result_bits == ACR_BITS_8;
  endproperty
  a_res_low: assert property (p_res_low) else $error("8-bit resolution wrong");

  property p_res_high;
    @(posedge clk) disable iff (sys_rst)
    (start_wr && state_q == ACR_IDLE && smpr_q[1]) |=> ##1 result_bits == ACR_BITS_12;
  endproperty
  a_res_high: assert property (p_res_high) else $error("12-bit resolution wrong");

  property p_busy_done;
    @(posedge clk) disable iff (sys_rst)
    conv_busy == !conv_done;
  endproperty
  a_busy_done: assert property (p_busy_done) else $error("done and busy disagree");

  property p_fast_tick;
    @(posedge clk) disable iff (sys_rst)
    (ckdiv_q == 2'h2) |=> tick_q;
  endproperty
  a_fast_tick: assert property (p_fast_tick) else $error("divide by 1 wrong");

  property p_half_tick;
    @(posedge clk) disable iff (sys_rst)
    (tick_q && ckdiv_q == 2'h3) ##1 (ckdiv_q == 2'h3) |-> !tick_q ##1 tick_q;
  endproperty
  a_half_tick: assert property (p_half_tick) else $error("divide by 2 wrong");

  property p_sample_wide;
    @(posedge clk) disable iff (sys_rst)
    (state_q == ACR_SAMPLE && tick_q && cfg_q.sample_pulse_width == 2'h3 && step_q != 4'h7)
      |=> state_q == ACR_SAMPLE;
  endproperty
  a_sample_wide: assert property (p_sample_wide) else $error("eight-clock sample cut");

  property p_unmapped_read;
    @(posedge clk) disable iff (sys_rst)
    (reg_rd && !(sel_refh || sel_smpr || sel_pins || sel_trim || sel_ctrl)) |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_ctrl_read;
    @(posedge clk) disable iff (sys_rst)
    (reg_rd && sel_ctrl) |=> !reg_rdata[ACR_BIT_START] && (reg_rdata[ACR_BIT_DONE] == conv_done);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

  property p_porta_write;
    @(posedge clk) disable iff (sys_rst)
    (reg_wr && sel_pins) |=> ##1 porta_analog_only == $past(reg_wdata[4:0], 2);
  endproperty
  a_porta_write: assert property (p_porta_write) else $error("port A write not applied");

  property p_portb_high;
    @(posedge clk) disable iff (sys_rst)
    (reg_wr && sel_smpr) |=> ##1 portb_analog_only[5:3] == $past(reg_wdata[6:4], 2);
  endproperty
  a_portb_high: assert property (p_portb_high) else $error("port B pins 3-5 wrong");

  property p_portb_low;
    @(posedge clk) disable iff (sys_rst)
    (reg_wr && sel_pins) |=> ##1 portb_analog_only[2:0] == $past(reg_wdata[7:5], 2);
  endproperty
  a_portb_low: assert property (p_portb_low) else $error("port B pins 0-2 wrong");

endmodule : acr_adc_config

// file: logic/acr_pkg.sv
package acr_pkg;
  // Register offsets (byte addresses in special-function space)
  localparam logic [7:0] ACR_OFF_REFH = 8'h13;
  localparam logic [7:0] ACR_OFF_SMPR = 8'h14;
  localparam logic [7:0] ACR_OFF_PINS = 8'h16;
  localparam logic [7:0] ACR_OFF_TRIM = 8'h17;
  localparam logic [7:0] ACR_OFF_CTRL = 8'h18;
  // Writable bit masks; other bits read zero
  localparam logic [7:0] ACR_MSK_REFH = 8'h83;
  localparam logic [7:0] ACR_MSK_SMPR = 8'h7F;
  localparam logic [7:0] ACR_MSK_PINS = 8'hFF;
  localparam logic [7:0] ACR_MSK_TRIM = 8'h3F;
  // Reset values
  localparam logic [7:0] ACR_RST_REFH = 8'h03;
  localparam logic [7:0] ACR_RST_SMPR = 8'h0A;
  localparam logic [7:0] ACR_RST_PINS = 8'h00;
  localparam logic [7:0] ACR_RST_TRIM = 8'h00;
  localparam logic [1:0] ACR_RST_CKDIV = 2'h0;
  // Field positions
  localparam int ACR_BIT_EXTREF = 7;
  localparam int ACR_BIT_SIGN = 5;
  localparam int ACR_BIT_START = 0;
  localparam int ACR_BIT_DONE = 1;
  localparam int ACR_POS_CKDIV = 4;
  // Converter clock dividers for codes 00..11
  localparam logic [4:0] ACR_DIV_00 = 5'h10;
  localparam logic [4:0] ACR_DIV_01 = 5'h08;
  localparam logic [4:0] ACR_DIV_10 = 5'h01;
  localparam logic [4:0] ACR_DIV_11 = 5'h02;
  // Converter clock periods in the whole conversion phase after sampling, one per result bit
  localparam logic [3:0] ACR_BITS_8 = 4'h8;
  localparam logic [3:0] ACR_BITS_10 = 4'hA;
  localparam logic [3:0] ACR_BITS_12 = 4'hC;

  typedef enum logic [1:0] {
    ACR_IDLE = 2'b00,
    ACR_SAMPLE = 2'b01,
    ACR_CONVERT = 2'b10
  } acr_state_e;

  typedef struct packed {
    logic ext_reference_enable;
    logic [1:0] internal_reference_level;
    logic [1:0] sample_pulse_width;
    logic [1:0] resolution_select;
    logic offset_trim_direction;
    logic [4:0] offset_trim_magnitude;
  } acr_cfg_s;
endpackage : acr_pkg

// file: test/acr_adc_config_tb.sv
`timescale 1ns/100ps
module acr_adc_config_tb;
  import acr_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_seen = 1'b0;
  logic [7:0] reg_rdata;
  logic ref_internal_en, ref_from_pin, conv_clk_en, sample_pulse, conv_busy, conv_done;
  logic trim_direction, meas_valid;
  logic [1:0] internal_reference_level;
  logic [4:0] porta_analog_only, trim_magnitude, meas_gap;
  logic [5:0] portb_analog_only;
  logic [3:0] result_bits, meas_ticks;
  logic [7:0] rd_q[$];
  logic [8:0] ms_q[$];
  logic [4:0] divs[4] = '{5'h10, 5'h08, 5'h01, 5'h02};
  int fails = 0;
  int comparisons = 0;
  integer seed = 32'h13BAAE42;
  always #2.5 clk = ~clk;

  acr_adc_config dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ref_internal_en(ref_internal_en), .ref_from_pin(ref_from_pin),
    .internal_reference_level(internal_reference_level),
    .porta_analog_only(porta_analog_only), .portb_analog_only(portb_analog_only),
    .conv_clk_en(conv_clk_en), .sample_pulse(sample_pulse), .conv_busy(conv_busy),
    .result_bits(result_bits), .trim_direction(trim_direction),
    .trim_magnitude(trim_magnitude), .conv_done(conv_done));
  acr_core_model model_u (.clk(clk), .sys_rst(sys_rst), .conv_clk_en(conv_clk_en),
    .sample_pulse(sample_pulse), .conv_busy(conv_busy), .meas_valid(meas_valid),
    .meas_ticks(meas_ticks), .meas_gap(meas_gap));

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One idle cycle after each access keeps strobes single-driven
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask : acc
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_q.push_back(exp);
    acc(1'b0, a, 8'h00);
  endtask : rd
  task automatic report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin
    rd_seen <= reg_rd;
    if (rd_seen) chk("read data", {1'b0, rd_q.pop_front()}, {1'b0, reg_rdata});
    if (meas_valid) chk("ticks and gap", ms_q.pop_front(), {meas_ticks, meas_gap});
  end

  initial begin
    repeat (50000) @(posedge clk);
    fails++;
    report_and_stop();
  end

  initial begin
    logic [31:0] v, w;
    int n;
    logic [8:0] exp_bits;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(ACR_OFF_REFH, 8'h03);
    rd(ACR_OFF_SMPR, 8'h0A);
    rd(ACR_OFF_PINS, 8'h00);
    rd(ACR_OFF_TRIM, 8'h00);
    rd(ACR_OFF_CTRL, 8'h02);
    chk("level after reset", 9'h003, {7'h00, internal_reference_level});
    chk("internal after reset", 9'h001, {8'h00, ref_internal_en});
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      w = $random(seed);
      acc(1'b1, ACR_OFF_PINS, v[7:0]);
      acc(1'b1, ACR_OFF_SMPR, w[7:0]);
      acc(1'b1, ACR_OFF_REFH, v[15:8]);
      acc(1'b1, ACR_OFF_TRIM, w[15:8]);
      acc(1'b1, 8'h20, v[7:0]);
      rd(ACR_OFF_SMPR, w[7:0] & 8'h7F);
      rd(ACR_OFF_PINS, v[7:0]);
      rd(ACR_OFF_REFH, v[15:8] & 8'h83);
      rd(ACR_OFF_TRIM, w[15:8] & 8'h3F);
      rd(8'h20, 8'h00);
      chk("porta pins", {4'h0, v[4:0]}, {4'h0, porta_analog_only});
      chk("portb pins", {3'h0, w[6:4], v[7:5]}, {3'h0, portb_analog_only});
    end
    $display("test masks and pins done");
    for (int ck = 0; ck < 4; ck++) begin
      for (int s = 0; s < 4; s++) begin
        v = $random(seed);
        acc(1'b1, ACR_OFF_REFH, {v[7], 5'h00, v[1:0]});
        acc(1'b1, ACR_OFF_SMPR, {4'h0, s[1:0], v[3:2]});
        acc(1'b1, ACR_OFF_TRIM, {2'h0, v[13:8]});
        ms_q.push_back({4'h1 << s, divs[ck]});
        acc(1'b1, ACR_OFF_CTRL, {2'h0, ck[1:0], 4'h1});
        n = 0;
        while (conv_busy !== 1'b1 && n < 20) begin
          @(posedge clk);
          n++;
        end
        chk("busy", 9'h001, {8'h00, conv_busy});
        rd(ACR_OFF_CTRL, {2'h0, ck[1:0], 4'h0});
        acc(1'b1, ACR_OFF_REFH, ~{v[7], 5'h00, v[1:0]});
        acc(1'b1, ACR_OFF_SMPR, {4'h0, s[1:0], ~v[3:2]});
        chk("ref from pin", {8'h00, v[7]}, {8'h00, ref_from_pin});
        chk("ref internal", {8'h00, !v[7]}, {8'h00, ref_internal_en});
        chk("ref level", {7'h00, v[1:0]}, {7'h00, internal_reference_level});
        exp_bits = v[3] ? 9'h00C : v[2] ? 9'h00A : 9'h008;
        chk("bits", exp_bits, {5'h00, result_bits});
        chk("trim", {3'h0, v[13:8]}, {3'h0, trim_direction, trim_magnitude});
        n = 0;
        while (conv_done !== 1'b1 && n < 2000) begin
          @(posedge clk);
          n++;
        end
        chk("done", 9'h001, {8'h00, conv_done});
        rd(ACR_OFF_CTRL, {2'h0, ck[1:0], 4'h2});
      end
    end
    $display("test conversions done");
    repeat (4) @(posedge clk);
    report_and_stop();
  end
endmodule : acr_adc_config_tb

// file: test/acr_core_model.sv
`timescale 1ns/100ps
module acr_core_model
  import acr_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic sys_rst, // Sync reset, high
  input wire logic conv_clk_en, // Converter tick
  input wire logic sample_pulse, // Sampling window
  input wire logic conv_busy, // Conversion running
  output logic meas_valid, // One-cycle report
  output logic [3:0] meas_ticks, // Ticks inside window
  output logic [4:0] meas_gap // Last tick spacing
);
  logic [4:0] gap_q;
  logic [3:0] tick_q;
  logic busy_q;
  // Report lands after busy falls, so a late tick cannot be missed
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gap_q <= 5'h00;
      tick_q <= 4'h0;
      busy_q <= 1'b0;
      meas_valid <= 1'b0;
      meas_ticks <= 4'h0;
      meas_gap <= 5'h00;
    end else begin
      busy_q <= conv_busy;
      meas_valid <= busy_q && !conv_busy;
      gap_q <= conv_clk_en ? 5'h01 : gap_q + 5'h01;
      if (conv_clk_en) meas_gap <= gap_q;
      if (sample_pulse && conv_clk_en) tick_q <= tick_q + 4'h1;
      if (busy_q && !conv_busy) begin
        meas_ticks <= tick_q;
        tick_q <= 4'h0;
      end
    end
  end
endmodule : acr_core_model
